// [src/wtb_cfg.svh]
`ifndef WTB_CFG_SVH
`define WTB_CFG_SVH
// Function
// RL1: Counter, compares and capture are 16 bits, reached as two byte accesses.
// RL2: One shared 8-bit holding register keeps the high byte.
// RL3: Low-byte write loads holding and new low byte in one cycle.
// RL4: Low-byte read copies that register's high byte into the holding register.
// RL5: Compare reads return both bytes directly, holding untouched.
// RL6: Software writes high byte first, reads low byte first.
// RL7: Main code masks interrupts around shared two-byte accesses.
// RL8: Both control registers are plain bytes, accessed in any order.
// RL9: Every request shows in the flag register, passed on only if masked in.
// RL10: Tick from prescaler or external pin edge; no source, no change.
// RL11: Buffered compares checked on every tick; results drive waveform outputs.
// RL12: Compare match on A or B sets that channel's match flag.
// RL13: Selected, optionally filtered capture edge stores the counter.
// RL14: Counter at zero is bottom, at all ones is max; both detected.
// RL15: Top is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture, by mode.
// RL16: Compare A as top in PWM allows only toggle output and is double buffered.
// RL17: Capture register as top frees compare A for PWM output.
// RL18: Control A holds two force bits; control B holds wave mode bits three and two.
// RL19: CPU counter write beats any clear or count in the same cycle.
// RL20: Flags clear on vector acknowledge or on a written one.
// RL21: High-byte writes only load the holding register.
// RL22: High-byte reads of counter or capture return the holding register.

`define WTB_ADDR_W 8
`define WTB_A_CTRL_A 8'h00
`define WTB_A_CTRL_B 8'h04
`define WTB_A_CNT_L 8'h08
`define WTB_A_CNT_H 8'h0C
`define WTB_A_CMPA_L 8'h10
`define WTB_A_CMPA_H 8'h14
`define WTB_A_CMPB_L 8'h18
`define WTB_A_CMPB_H 8'h1C
`define WTB_A_CAP_L 8'h20
`define WTB_A_CAP_H 8'h24
`define WTB_A_FLAG 8'h28
`define WTB_A_MASK 8'h2C

`define WTB_CTRL_A_RST 8'h00
`define WTB_CTRL_B_RST 8'h00
`define WTB_WIDE_RST 16'h0000
`define WTB_BYTE_RST 8'h00
`define WTB_FLAG_RST 4'h0

`define WTB_BOTTOM 16'h0000
`define WTB_MAX 16'hFFFF
`define WTB_TOP8 16'h00FF
`define WTB_TOP9 16'h01FF
`define WTB_TOP10 16'h03FF
`define WTB_ONE 16'h0001

`define WTB_COMA_HI 7
`define WTB_COMA_LO 6
`define WTB_COMB_HI 5
`define WTB_COMB_LO 4
`define WTB_FORCE_A 3
`define WTB_FORCE_B 2
`define WTB_WAVE_HI 1
`define WTB_WAVE_LO 0
`define WTB_FORCE_MASK 8'h0C

`define WTB_NOISE_EN 7
`define WTB_CAP_RISE 6
`define WTB_CAP_ACMP 5
`define WTB_WAVE3 4
`define WTB_WAVE2 3
`define WTB_CS_HI 2
`define WTB_CS_LO 0

`define WTB_FLAG_W 4
`define WTB_F_OVF 0
`define WTB_F_MB 1
`define WTB_F_MA 2
`define WTB_F_CAP 3

`define WTB_CS_OFF 3'h0
`define WTB_CS_CLK 3'h1
`define WTB_CS_D8 3'h2
`define WTB_CS_D64 3'h3
`define WTB_CS_D256 3'h4
`define WTB_CS_D1024 3'h5
`define WTB_CS_FALL 3'h6
`define WTB_CS_RISE 3'h7

`define WTB_PRE_W 10
`define WTB_TAP8 2
`define WTB_TAP64 5
`define WTB_TAP256 7
`define WTB_TAP1024 9

`define WTB_COM_OFF 2'h0
`define WTB_COM_TOG 2'h1
`define WTB_COM_CLR 2'h2
`define WTB_COM_SET 2'h3

`define WTB_FILTER_LEN 4
`endif

// [src/wtb_pkg.sv]
package wtb_pkg;
	typedef enum logic {
		WTB_UP,
		WTB_DOWN
	} wtb_dir_t;

	typedef enum logic [1:0] {
		WTB_NONPWM,
		WTB_FAST,
		WTB_PHASE,
		WTB_PFC
	} wtb_kind_t;
endpackage : wtb_pkg

// [src/wtb_edge_if.sv]
`timescale 1ns/1ps
interface wtb_edge_if;
	logic raw;
	logic filter_en;
	logic rise_sel;
	logic edge_seen;

	modport src (output raw, output filter_en, output rise_sel, input edge_seen);
	modport det (input raw, input filter_en, input rise_sel, output edge_seen);
endinterface : wtb_edge_if

// [src/wtb_edge.sv]
`timescale 1ns/1ps
`include "wtb_cfg.svh"
module wtb_edge #(
	parameter int FILTER_LEN = `WTB_FILTER_LEN
) (
	input wire logic core_clk,
	input wire logic rst_n,
	wtb_edge_if.det  eif
);
	logic                  sample_r;
	logic                  sample_nxt;
	logic [FILTER_LEN-1:0] hist_r;
	logic [FILTER_LEN-1:0] hist_nxt;
	logic                  level_r;
	logic                  level_nxt;
	logic                  edge_r;
	logic                  edge_nxt;

	always_comb begin
		sample_nxt = eif.raw;
		hist_nxt   = {hist_r[FILTER_LEN-2:0], sample_r};
		level_nxt  = level_r;
		if (!eif.filter_en) begin
			level_nxt = sample_r;
		end else if (&hist_r) begin // see RL13
			level_nxt = 1'b1;
		end else if (~|hist_r) begin
			level_nxt = 1'b0;
		end
		// Turning the filter off can fake one edge; changing polarity alone cannot
		edge_nxt = (level_nxt != level_r) && (level_nxt == eif.rise_sel); // see RL13
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_r <= 1'b0;
			hist_r   <= '0;
			level_r  <= 1'b0;
			edge_r   <= 1'b0;
		end else begin
			sample_r <= sample_nxt;
			hist_r   <= hist_nxt;
			level_r  <= level_nxt;
			edge_r   <= edge_nxt;
		end
	end

	assign eif.edge_seen = edge_r;
endmodule : wtb_edge

// [src/wtb_timer.sv]
`timescale 1ns/1ps
`include "wtb_cfg.svh"
module wtb_timer (
	input  wire logic                     core_clk,
	input  wire logic                     rst_n,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`WTB_ADDR_W-1:0]   paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     ext_count_pin,
	input  wire logic                     capture_pin,
	input  wire logic                     comparator_out,
	input  wire logic [`WTB_FLAG_W-1:0]   irq_ack,
	output logic      [`WTB_FLAG_W-1:0]   irq_req,
	output logic                          compare_out_a,
	output logic                          compare_out_b,
	output logic                          compare_oe_a,
	output logic                          compare_oe_b
);
	logic [7:0]              ctrl_a_r, ctrl_a_nxt;
	logic [7:0]              ctrl_b_r, ctrl_b_nxt;
	logic [15:0]             count_r, count_nxt;
	logic [7:0]              temp_r, temp_nxt;
	logic [15:0]             cmpa_buf_r, cmpa_buf_nxt;
	logic [15:0]             cmpa_r, cmpa_nxt;
	logic [15:0]             cmpb_buf_r, cmpb_buf_nxt;
	logic [15:0]             cmpb_r, cmpb_nxt;
	logic [15:0]             cap_r, cap_nxt;
	logic [`WTB_FLAG_W-1:0]  flag_r, flag_nxt;
	logic [`WTB_FLAG_W-1:0]  mask_r, mask_nxt;
	logic [`WTB_PRE_W-1:0]   pre_r, pre_nxt;
	wtb_pkg::wtb_dir_t       dir_r, dir_nxt;
	logic                    out_a_r, out_a_nxt;
	logic                    out_b_r, out_b_nxt;
	logic [31:0]             rdata_r, rdata_nxt;
	logic                    err_r, err_nxt;

	logic [3:0]              mode;
	logic [2:0]              clk_sel;
	wtb_pkg::wtb_kind_t      kind;
	logic [15:0]             top;
	logic                    cap_is_top;
	logic                    cmpa_is_top;
	logic                    tick;
	logic                    at_bottom;
	logic                    at_max;
	logic                    at_top;
	logic                    setup_rd;
	logic                    setup_ph;
	logic                    wr_acc;
	logic [7:0]              wbyte;
	logic [7:0]              rbyte;
	logic                    hit;
	logic                    match_a;
	logic                    match_b;
	logic                    force_a;
	logic                    force_b;
	logic                    wrap;
	logic                    upd;
	logic [`WTB_FLAG_W-1:0]  set_vec;
	logic [`WTB_FLAG_W-1:0]  clr_vec;

	wtb_edge_if ext_if ();
	wtb_edge_if cap_if ();

	wtb_edge #(.FILTER_LEN(`WTB_FILTER_LEN)) u_ext_edge (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.eif      (ext_if.det)
	);

	wtb_edge #(.FILTER_LEN(`WTB_FILTER_LEN)) u_cap_edge (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.eif      (cap_if.det)
	);

	assign clk_sel          = ctrl_b_r[`WTB_CS_HI:`WTB_CS_LO];
	assign ext_if.raw       = ext_count_pin;
	assign ext_if.filter_en = 1'b0;
	assign ext_if.rise_sel  = (clk_sel == `WTB_CS_RISE); // see RL10
	assign cap_if.raw       = ctrl_b_r[`WTB_CAP_ACMP] ? comparator_out : capture_pin; // see RL13
	assign cap_if.filter_en = ctrl_b_r[`WTB_NOISE_EN];
	assign cap_if.rise_sel  = ctrl_b_r[`WTB_CAP_RISE];

	assign mode = {ctrl_b_r[`WTB_WAVE3], ctrl_b_r[`WTB_WAVE2], ctrl_a_r[`WTB_WAVE_HI:`WTB_WAVE_LO]}; // see RL18

	// Mode decode
	always_comb begin
		kind        = wtb_pkg::WTB_NONPWM;
		top         = `WTB_MAX;
		cap_is_top  = 1'b0;
		cmpa_is_top = 1'b0;
		case (mode) // see RL15
			4'h0: top = `WTB_MAX;
			4'h1: begin kind = wtb_pkg::WTB_PHASE; top = `WTB_TOP8; end
			4'h2: begin kind = wtb_pkg::WTB_PHASE; top = `WTB_TOP9; end
			4'h3: begin kind = wtb_pkg::WTB_PHASE; top = `WTB_TOP10; end
			4'h4: begin top = cmpa_r; cmpa_is_top = 1'b1; end
			4'h5: begin kind = wtb_pkg::WTB_FAST; top = `WTB_TOP8; end
			4'h6: begin kind = wtb_pkg::WTB_FAST; top = `WTB_TOP9; end
			4'h7: begin kind = wtb_pkg::WTB_FAST; top = `WTB_TOP10; end
			4'h8: begin kind = wtb_pkg::WTB_PFC; top = cap_r; cap_is_top = 1'b1; end // see RL17
			4'h9: begin kind = wtb_pkg::WTB_PFC; top = cmpa_r; cmpa_is_top = 1'b1; end // see RL16
			4'hA: begin kind = wtb_pkg::WTB_PHASE; top = cap_r; cap_is_top = 1'b1; end
			4'hB: begin kind = wtb_pkg::WTB_PHASE; top = cmpa_r; cmpa_is_top = 1'b1; end
			4'hC: begin top = cap_r; cap_is_top = 1'b1; end
			4'hE: begin kind = wtb_pkg::WTB_FAST; top = cap_r; cap_is_top = 1'b1; end
			4'hF: begin kind = wtb_pkg::WTB_FAST; top = cmpa_r; cmpa_is_top = 1'b1; end
			default: top = `WTB_MAX;
		endcase
	end

	// Free prescaler: first tick lands anywhere
	always_comb begin
		case (clk_sel) // see RL10
			`WTB_CS_OFF:   tick = 1'b0;
			`WTB_CS_CLK:   tick = 1'b1;
			`WTB_CS_D8:    tick = &pre_r[`WTB_TAP8:0];
			`WTB_CS_D64:   tick = &pre_r[`WTB_TAP64:0];
			`WTB_CS_D256:  tick = &pre_r[`WTB_TAP256:0];
			`WTB_CS_D1024: tick = &pre_r[`WTB_TAP1024:0];
			default:       tick = ext_if.edge_seen;
		endcase
	end

	assign at_bottom = (count_r == `WTB_BOTTOM); // see RL14
	assign at_max    = (count_r == `WTB_MAX);    // see RL14
	assign at_top    = (count_r == top);
	assign match_a   = tick && (count_r == cmpa_r); // see RL11
	assign match_b   = tick && (count_r == cmpb_r); // see RL11

	assign setup_ph = psel && !penable;
	assign setup_rd = setup_ph && !pwrite;
	assign wr_acc   = psel && penable && pwrite;
	assign wbyte    = pwdata[7:0]; // see RL1
	assign force_a  = wr_acc && (paddr == `WTB_A_CTRL_A) && wbyte[`WTB_FORCE_A] && (kind == wtb_pkg::WTB_NONPWM);
	assign force_b  = wr_acc && (paddr == `WTB_A_CTRL_A) && wbyte[`WTB_FORCE_B] && (kind == wtb_pkg::WTB_NONPWM);

	function automatic logic out_next(
		input logic               cur,
		input logic [1:0]         com,
		input wtb_pkg::wtb_kind_t knd,
		input logic               match,
		input logic               frc,
		input logic               at_wrap,
		input wtb_pkg::wtb_dir_t  dir,
		input logic               tog_ok
	);
		logic v;
		v = cur;
		case (knd)
			wtb_pkg::WTB_NONPWM: begin
				if (match || frc) begin
					case (com)
						`WTB_COM_TOG: v = ~cur;
						`WTB_COM_CLR: v = 1'b0;
						`WTB_COM_SET: v = 1'b1;
						default:      v = cur;
					endcase
				end
			end
			wtb_pkg::WTB_FAST: begin
				if (at_wrap) begin
					v = (com == `WTB_COM_CLR);
				end
				if (match) begin
					v = (com == `WTB_COM_TOG && tog_ok) ? ~cur : (com == `WTB_COM_SET);
				end
			end
			default: begin
				if (match) begin
					if (com == `WTB_COM_TOG && tog_ok) begin
						v = ~cur;
					end else begin
						v = (dir == wtb_pkg::WTB_UP) ? (com == `WTB_COM_SET) : (com == `WTB_COM_CLR);
					end
				end
			end
		endcase
		return v;
	endfunction : out_next

	always_comb begin
		ctrl_a_nxt   = ctrl_a_r;
		ctrl_b_nxt   = ctrl_b_r;
		count_nxt    = count_r;
		temp_nxt     = temp_r;
		cmpa_buf_nxt = cmpa_buf_r;
		cmpa_nxt     = cmpa_r;
		cmpb_buf_nxt = cmpb_buf_r;
		cmpb_nxt     = cmpb_r;
		cap_nxt      = cap_r;
		mask_nxt     = mask_r;
		pre_nxt      = pre_r + `WTB_PRE_W'(1);
		dir_nxt      = dir_r;
		rdata_nxt    = rdata_r;
		err_nxt      = err_r;
		rbyte        = `WTB_BYTE_RST;
		hit          = 1'b1;
		set_vec      = '0;
		clr_vec      = '0;
		wrap         = 1'b0;
		upd          = 1'b0;

		// Counting sequence
		if (tick) begin
			case (kind)
				wtb_pkg::WTB_NONPWM,
				wtb_pkg::WTB_FAST: begin
					wrap      = at_top || at_max;
					count_nxt = wrap ? `WTB_BOTTOM : count_r + `WTB_ONE;
					set_vec[`WTB_F_OVF] = (kind == wtb_pkg::WTB_NONPWM) ? at_max : at_top;
					upd = (kind == wtb_pkg::WTB_FAST) && at_top;
				end
				default: begin
					if (dir_r == wtb_pkg::WTB_UP) begin
						if (at_top) begin
							dir_nxt   = wtb_pkg::WTB_DOWN;
							count_nxt = count_r - `WTB_ONE;
							upd       = (kind == wtb_pkg::WTB_PHASE);
						end else begin
							count_nxt = count_r + `WTB_ONE;
						end
					end else if (at_bottom) begin
						dir_nxt   = wtb_pkg::WTB_UP;
						count_nxt = count_r + `WTB_ONE;
						upd       = (kind == wtb_pkg::WTB_PFC);
						set_vec[`WTB_F_OVF] = 1'b1;
					end else begin
						count_nxt = count_r - `WTB_ONE;
					end
				end
			endcase
		end
		if (kind == wtb_pkg::WTB_NONPWM) begin
			dir_nxt = wtb_pkg::WTB_UP;
			upd     = 1'b1;
		end

		// Buffers load at the update point
		if (upd) begin // see RL16
			cmpa_nxt = cmpa_buf_r;
			cmpb_nxt = cmpb_buf_r;
		end

		set_vec[`WTB_F_MA] = match_a; // see RL12
		set_vec[`WTB_F_MB] = match_b; // see RL12

		// Capture input dead while it is top
		if (cap_if.edge_seen && !cap_is_top) begin // see RL13
			cap_nxt = count_r;
			set_vec[`WTB_F_CAP] = 1'b1;
		end

		// Read snapshot at setup, with holding side effect
		if (setup_ph) begin
			case (paddr)
				`WTB_A_CTRL_A: rbyte = ctrl_a_r; // see RL8
				`WTB_A_CTRL_B: rbyte = ctrl_b_r; // see RL8
				`WTB_A_CNT_L:  begin rbyte = count_r[7:0]; if (setup_rd) temp_nxt = count_r[15:8]; end // see RL4
				`WTB_A_CNT_H:  rbyte = temp_r; // see RL22
				`WTB_A_CMPA_L: rbyte = cmpa_buf_r[7:0];  // see RL5
				`WTB_A_CMPA_H: rbyte = cmpa_buf_r[15:8]; // see RL5
				`WTB_A_CMPB_L: rbyte = cmpb_buf_r[7:0];  // see RL5
				`WTB_A_CMPB_H: rbyte = cmpb_buf_r[15:8]; // see RL5
				`WTB_A_CAP_L:  begin rbyte = cap_r[7:0]; if (setup_rd) temp_nxt = cap_r[15:8]; end // see RL4
				`WTB_A_CAP_H:  rbyte = temp_r; // see RL22
				`WTB_A_FLAG:   rbyte = {{(8-`WTB_FLAG_W){1'b0}}, flag_r}; // see RL9
				`WTB_A_MASK:   rbyte = {{(8-`WTB_FLAG_W){1'b0}}, mask_r};
				default:       hit = 1'b0;
			endcase
			rdata_nxt = setup_rd ? {24'h000000, rbyte} : 32'h00000000;
			err_nxt   = !hit;
		end

		// Writes land at access, beating counting
		if (wr_acc) begin
			case (paddr)
				`WTB_A_CTRL_A: ctrl_a_nxt = wbyte & ~`WTB_FORCE_MASK; // see RL18
				`WTB_A_CTRL_B: ctrl_b_nxt = wbyte; // see RL8
				`WTB_A_CNT_L:  count_nxt = {temp_r, wbyte}; // see RL3, see RL19
				`WTB_A_CMPA_L: cmpa_buf_nxt = {temp_r, wbyte}; // see RL3
				`WTB_A_CMPB_L: cmpb_buf_nxt = {temp_r, wbyte}; // see RL3
				`WTB_A_CAP_L:  if (cap_is_top) cap_nxt = {temp_r, wbyte}; // see RL3
				`WTB_A_CNT_H,
				`WTB_A_CMPA_H,
				`WTB_A_CMPB_H,
				`WTB_A_CAP_H:  temp_nxt = wbyte; // see RL2, see RL21
				`WTB_A_FLAG:   clr_vec = wbyte[`WTB_FLAG_W-1:0]; // see RL20
				`WTB_A_MASK:   mask_nxt = wbyte[`WTB_FLAG_W-1:0];
				default:       temp_nxt = temp_r;
			endcase
		end

		// Set beats clear
		flag_nxt = (flag_r & ~(clr_vec | irq_ack)) | set_vec; // see RL20

		out_a_nxt = out_next(out_a_r, ctrl_a_r[`WTB_COMA_HI:`WTB_COMA_LO], kind, match_a, force_a,
			tick && wrap, dir_r, cmpa_is_top); // see RL11
		out_b_nxt = out_next(out_b_r, ctrl_a_r[`WTB_COMB_HI:`WTB_COMB_LO], kind, match_b, force_b,
			tick && wrap, dir_r, 1'b0); // see RL11
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a_r   <= `WTB_CTRL_A_RST;
			ctrl_b_r   <= `WTB_CTRL_B_RST;
			count_r    <= `WTB_WIDE_RST;
			temp_r     <= `WTB_BYTE_RST;
			cmpa_buf_r <= `WTB_WIDE_RST;
			cmpa_r     <= `WTB_WIDE_RST;
			cmpb_buf_r <= `WTB_WIDE_RST;
			cmpb_r     <= `WTB_WIDE_RST;
			cap_r      <= `WTB_WIDE_RST;
			flag_r     <= `WTB_FLAG_RST;
			mask_r     <= `WTB_FLAG_RST;
			pre_r      <= '0;
			dir_r      <= wtb_pkg::WTB_UP;
			out_a_r    <= 1'b0;
			out_b_r    <= 1'b0;
			rdata_r    <= 32'h00000000;
			err_r      <= 1'b0;
		end else begin
			ctrl_a_r   <= ctrl_a_nxt;
			ctrl_b_r   <= ctrl_b_nxt;
			count_r    <= count_nxt;
			temp_r     <= temp_nxt;
			cmpa_buf_r <= cmpa_buf_nxt;
			cmpa_r     <= cmpa_nxt;
			cmpb_buf_r <= cmpb_buf_nxt;
			cmpb_r     <= cmpb_nxt;
			cap_r      <= cap_nxt;
			flag_r     <= flag_nxt;
			mask_r     <= mask_nxt;
			pre_r      <= pre_nxt;
			dir_r      <= dir_nxt;
			out_a_r    <= out_a_nxt;
			out_b_r    <= out_b_nxt;
			rdata_r    <= rdata_nxt;
			err_r      <= err_nxt;
		end
	end

	assign prdata        = rdata_r;
	assign pready        = 1'b1;
	assign pslverr       = err_r;
	assign irq_req       = flag_r & mask_r; // see RL9
	assign compare_out_a = out_a_r;
	assign compare_out_b = out_b_r;
	// Compare A as period gives no PWM
	assign compare_oe_a  = (ctrl_a_r[`WTB_COMA_HI:`WTB_COMA_LO] != `WTB_COM_OFF) &&
		!(kind != wtb_pkg::WTB_NONPWM && cmpa_is_top &&
		ctrl_a_r[`WTB_COMA_HI:`WTB_COMA_LO] != `WTB_COM_TOG); // see RL16
	assign compare_oe_b  = (ctrl_a_r[`WTB_COMB_HI:`WTB_COMB_LO] != `WTB_COM_OFF) &&
		!(kind != wtb_pkg::WTB_NONPWM && ctrl_a_r[`WTB_COMB_HI:`WTB_COMB_LO] == `WTB_COM_TOG);
endmodule : wtb_timer

// [test/wtb_timer_checker.sv]
`timescale 1ns/1ps
`include "wtb_cfg.svh"
module wtb_timer_checker (
	input wire logic                   core_clk,
	input wire logic                   rst_n,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [`WTB_ADDR_W-1:0] paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic [`WTB_FLAG_W-1:0] irq_ack,
	input wire logic [`WTB_FLAG_W-1:0] irq_req,
	input wire logic                   compare_oe_a,
	input wire logic                   compare_oe_b
);
	logic [7:0]  hold_r;
	logic [7:0]  ctla_r;
	logic [7:0]  ctlb_r;
	logic [7:0]  mask_r;
	logic [15:0] cnt_r;
	logic [15:0] cmpa_r;
	logic [15:0] cmpb_r;
	logic        hok_r;
	logic        cok_r;
	logic [2:0]  idle_r;
	wire         wr = psel & penable & pwrite;
	wire         rd = psel & penable & ~pwrite;

	// Count shadow trusted only once counting has stopped; compare shadows always
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r <= 8'h00;
			ctla_r <= 8'h00;
			ctlb_r <= 8'h00;
			mask_r <= 8'h00;
			cnt_r  <= 16'h0000;
			cmpa_r <= 16'h0000;
			cmpb_r <= 16'h0000;
			hok_r  <= 1'h1;
			cok_r  <= 1'h1;
			idle_r <= 3'h7;
		end else begin
			idle_r <= (ctlb_r[2:0] != 3'h0) ? 3'h0 : idle_r + 3'(idle_r != 3'h7);
			if (wr) begin
				case (paddr)
					`WTB_A_CTRL_A: ctla_r <= pwdata[7:0];
					`WTB_A_CTRL_B: ctlb_r <= pwdata[7:0];
					`WTB_A_MASK: mask_r <= pwdata[7:0];
					`WTB_A_CMPA_L: cmpa_r <= {hold_r, pwdata[7:0]};
					`WTB_A_CMPB_L: cmpb_r <= {hold_r, pwdata[7:0]};
					`WTB_A_CNT_L: begin
						cnt_r <= {hold_r, pwdata[7:0]};
						cok_r <= hok_r;
					end
					`WTB_A_CNT_H, `WTB_A_CMPA_H, `WTB_A_CMPB_H, `WTB_A_CAP_H: begin
						hold_r <= pwdata[7:0];
						hok_r  <= 1'h1;
					end
					default: ;
				endcase
			end
			if (rd && paddr == `WTB_A_CNT_L) begin
				hold_r <= cnt_r[15:8];
				hok_r  <= cok_r && idle_r == 3'h7;
			end
			if (rd && paddr == `WTB_A_CAP_L)
				hok_r <= 1'h0;
			if (ctlb_r[2:0] != 3'h0)
				cok_r <= 1'h0;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	irq_gate_a: assert property (
		(irq_req & ~mask_r[3:0]) == 4'h0) else $error("masked request passed");
	ctrlb_read_a: assert property (
		rd && paddr == `WTB_A_CTRL_B |-> prdata == {24'h000000, ctlb_r}) else $error("control b readback");
	hold_read_a: assert property (
		rd && hok_r && (paddr == `WTB_A_CNT_H || paddr == `WTB_A_CAP_H) |-> prdata[7:0] == hold_r)
		else $error("holding byte");
	cnt_read_a: assert property (
		rd && cok_r && idle_r == 3'h7 && paddr == `WTB_A_CNT_L |-> prdata[7:0] == cnt_r[7:0])
		else $error("count low byte");
	cmpa_high_a: assert property (
		rd && paddr == `WTB_A_CMPA_H |-> prdata[7:0] == cmpa_r[15:8]) else $error("compare a high");
	cmpb_low_a: assert property (
		rd && paddr == `WTB_A_CMPB_L |-> prdata[7:0] == cmpb_r[7:0]) else $error("compare b low");
	flag_clear_a: assert property (
		wr && paddr == `WTB_A_FLAG && idle_r == 3'h7 |=> (irq_req[2:0] & $past(pwdata[2:0])) == 3'h0)
		else $error("write clear");
	ack_clear_a: assert property (
		irq_ack[2:0] != 3'h0 && idle_r == 3'h7 |=> (irq_req[2:0] & $past(irq_ack[2:0])) == 3'h0)
		else $error("ack clear");
	bad_addr_a: assert property (
		psel && penable && (paddr[1:0] != 2'h0 || paddr > `WTB_A_MASK) |-> pslverr) else $error("no slave error");
	oe_idle_a: assert property (
		ctla_r[7:4] == 4'h0 |-> !compare_oe_a && !compare_oe_b) else $error("pin driven while off");
endmodule : wtb_timer_checker

bind wtb_timer wtb_timer_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq_ack(irq_ack), .irq_req(irq_req), .compare_oe_a(compare_oe_a), .compare_oe_b(compare_oe_b));

// [test/wtb_cpu.sv]
`timescale 1ns/1ps
module wtb_cpu (
	input  wire logic        core_clk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	logic err;

	// Single master, so no masking needed
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		err = 1'h0;
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1'h1;
		do
			@(posedge core_clk);
		while (pready !== 1'h1);
		q = prdata[7:0];
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		paddr   <= ~a;
		pwdata  <= ~pwdata;
		@(posedge core_clk);
	endtask : xfer

	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		logic [7:0] q;
		xfer(1'h1, a + 8'h04, v[15:8], q);
		xfer(1'h1, a, v[7:0], q);
	endtask : wr16

	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		xfer(1'h0, a, 8'h00, v[7:0]);
		xfer(1'h0, a + 8'h04, 8'h00, v[15:8]);
	endtask : rd16
endmodule : wtb_cpu

// [test/wtb_timer_tb_top.sv]
`timescale 1ns/1ps
`include "wtb_cfg.svh"
module wtb_timer_tb_top;
	logic        core_clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_count_pin;
	logic        capture_pin;
	logic        comparator_out;
	logic [3:0]  irq_ack;
	logic [3:0]  irq_req;
	int          failures;
	int          comparisons;
	int          n;
	logic [31:0] seed;
	logic [15:0] q;
	logic [15:0] v;
	logic [7:0]  b;
	logic [7:0]  ctl;
	logic [15:0] last[3];
	logic [7:0]  lows[3] = '{`WTB_A_CNT_L, `WTB_A_CMPA_L, `WTB_A_CMPB_L};
	logic [2:0]  ext_cs[2] = '{`WTB_CS_RISE, `WTB_CS_FALL};

	always #5 core_clk = ~core_clk;

	wtb_timer u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_count_pin(ext_count_pin), .capture_pin(capture_pin), .comparator_out(comparator_out),
		.irq_ack(irq_ack), .irq_req(irq_req), .compare_out_a(), .compare_out_b(), .compare_oe_a(),
		.compare_oe_b());
	wtb_cpu u_cpu (.core_clk(core_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_cpu.xfer(1'h1, a, d, b);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		u_cpu.xfer(1'h0, a, 8'h00, b);
	endtask : rd

	task automatic run(input logic [2:0] cs);
		wr(`WTB_A_CTRL_B, {5'h00, cs});
	endtask : run

	task automatic wait_irq(input int k);
		n = 0;
		while (irq_req[k] !== 1'h1 && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		chk(16'(irq_req[k]), 16'h0001);
	endtask : wait_irq

	task automatic give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	// Under a thousand cycles needed; hangs cut here
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		give_verdict();
	end

	initial begin
		core_clk = 1'h0;
		rst_n = 1'h0;
		ext_count_pin = 1'h0;
		capture_pin = 1'h0;
		comparator_out = 1'h0;
		irq_ack = 4'h0;
		failures = 0;
		comparisons = 0;
		seed = 32'hC9D2A5EC;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
		for (int a = 0; a < 56; a += 4) begin
			rd(8'(a));
			chk({7'h00, u_cpu.err, b}, {7'h00, a > 44, 8'h00});
		end
		rd(8'h02);
		chk(16'(u_cpu.err), 16'h0001);
		$display("reset and map done");
		foreach (lows[i]) repeat (3) begin
			seed = xs(seed);
			last[i] = seed[15:0];
			u_cpu.wr16(lows[i], last[i]);
			u_cpu.rd16(lows[i], q);
			chk(q, last[i]);
		end
		wr(`WTB_A_CNT_H, 8'h5A);
		rd(`WTB_A_CMPA_H);
		chk(16'(b), 16'(last[1][15:8]));
		rd(`WTB_A_CNT_H);
		chk(16'(b), 16'h005A);
		wr(`WTB_A_CMPA_L, 8'h11);
		wr(`WTB_A_CMPB_L, 8'h22);
		u_cpu.rd16(`WTB_A_CNT_L, q);
		chk(q, last[0]);
		u_cpu.rd16(`WTB_A_CMPB_L, q);
		chk(q, 16'h5A22);
		$display("wide access done");
		repeat (4) begin
			seed = xs(seed);
			ctl = seed[7:0];
			wr(`WTB_A_CTRL_B, {ctl[7:3], 3'h0});
			wr(`WTB_A_CTRL_A, ctl);
			rd(`WTB_A_CTRL_A);
			chk(16'(b & ~`WTB_FORCE_MASK), 16'(ctl & ~`WTB_FORCE_MASK));
			rd(`WTB_A_CTRL_B);
			chk(16'(b), 16'({ctl[7:3], 3'h0}));
		end
		wr(`WTB_A_CTRL_A, 8'h00);
		run(`WTB_CS_OFF);
		$display("control done");
		wr(`WTB_A_MASK, 8'h0F);
		u_cpu.wr16(`WTB_A_CMPA_L, 16'h0010);
		u_cpu.wr16(`WTB_A_CNT_L, 16'h0000);
		wr(`WTB_A_FLAG, 8'h0F);
		run(`WTB_CS_CLK);
		wait_irq(`WTB_F_MA);
		run(`WTB_CS_OFF);
		wr(`WTB_A_FLAG, 8'h04);
		chk(16'(irq_req), 16'h0000);
		wr(`WTB_A_MASK, 8'h00);
		run(`WTB_CS_CLK);
		u_cpu.wr16(`WTB_A_CNT_L, 16'h1200);
		run(`WTB_CS_OFF);
		u_cpu.rd16(`WTB_A_CNT_L, q);
		chk(16'(q - 16'h1200 < 16'h0008), 16'h0001);
		run(`WTB_CS_CLK);
		u_cpu.wr16(`WTB_A_CNT_L, 16'hFFF0);
		repeat (40) @(posedge core_clk);
		chk(16'(irq_req), 16'h0000);
		rd(`WTB_A_FLAG);
		chk(16'(b[`WTB_F_OVF]), 16'h0001);
		run(`WTB_CS_OFF);
		wr(`WTB_A_MASK, 8'h01);
		repeat (8) @(posedge core_clk);
		chk(16'(irq_req[`WTB_F_OVF]), 16'h0001);
		irq_ack <= 4'h1;
		@(posedge core_clk);
		irq_ack <= 4'h0;
		@(posedge core_clk);
		chk(16'(irq_req[`WTB_F_OVF]), 16'h0000);
		$display("counting done");
		foreach (ext_cs[k]) begin
			seed = xs(seed);
			n = int'(seed[2:0]) + 1;
			u_cpu.wr16(`WTB_A_CNT_L, 16'h0000);
			run(ext_cs[k]);
			repeat (n) begin
				ext_count_pin <= 1'h1;
				repeat (3) @(posedge core_clk);
				ext_count_pin <= 1'h0;
				repeat (3) @(posedge core_clk);
			end
			run(`WTB_CS_OFF);
			u_cpu.rd16(`WTB_A_CNT_L, q);
			chk(q, 16'(n));
		end
		$display("external count done");
		wr(`WTB_A_MASK, 8'h08);
		for (int s = 0; s < 2; s++) begin
			wr(`WTB_A_CTRL_B, {2'h1, s[0], 2'h0, `WTB_CS_CLK});
			wr(`WTB_A_FLAG, 8'h0F);
			u_cpu.wr16(`WTB_A_CNT_L, 16'h0000);
			repeat (20) @(posedge core_clk);
			capture_pin <= !s[0];
			comparator_out <= s[0];
			wait_irq(`WTB_F_CAP);
			run(`WTB_CS_OFF);
			u_cpu.rd16(`WTB_A_CAP_L, q);
			u_cpu.rd16(`WTB_A_CNT_L, v);
			chk(16'(q != 16'h0000 && q < v), 16'h0001);
			capture_pin <= 1'h0;
			comparator_out <= 1'h0;
			repeat (4) @(posedge core_clk);
		end
		$display("capture done");
		give_verdict();
	end
endmodule : wtb_timer_tb_top
